// >>> core/prq_core.sv
// Peripheral register image with power-on and operating reset handling
// Overview of operation
// - Any reset clears all pending interrupt request flags.
// - Any reset clears all interrupt enable flags.
// - Any reset clears the interrupt priority flag.
// - Any reset clears the interrupt master enable.
// - Any reset clears the three external interrupt mode registers.
// - Any reset clears port direction flags, so all pins are inputs.
// - Any reset clears the pull-up assignment registers.
// - Any reset clears the basic timer output enable.
// - Any reset clears timer 0 output enable, count and mode.
// - Any reset clears the watch timer mode register.
// - Any reset clears the LCD mode register.
// - Any reset clears the LCD control register.
// - Any reset clears the serial mode register.
// - Serial buffer kept on operating reset, undefined on power-on.
// - PLL mode kept on operating reset, undefined on power-on.
// - PLL divider data kept on operating reset, undefined on power-on.
// - Operating reset: lock undefined, CE flag from pin, count flag 0.
// - Power-on: lock and count flags undefined, CE flag 0 until release, then follows pin.
// - Any reset clears the IF counter mode register.
// - Any reset clears both halves of the IF counter.
// - Any reset clears the A/D mode register.
// - Any reset clears the A/D result register.
// - Reset starts from the reset pin or a chip-enable rising edge.
`timescale 1ns/1ps
module prq_core (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 reset_pin_n,
	input  wire logic                 ce_pin,
	input  wire logic                 pll_lock_pin,
	input  wire logic [7:0]           irq_event,
	input  wire logic                 if_done,
	input  wire logic [15:0]          if_value,
	input  wire logic                 adc_done,
	input  wire logic [7:0]           adc_data,
	input  wire prq_pkg::prq_wr_t     wr,
	output prq_pkg::prq_state_t       regs,
	output logic                      op_reset_active
);
	// ==========================================================
	// Pin synchronizers and reset source
	logic [2:0] pins_s;
	logic       reset_pin_n_s;
	logic       ce_s;
	logic       lock_s;
	logic       op_reset;

	prq_sync #(
		.W   (3),
		.RST (3'b100)
	) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.din  ({reset_pin_n, ce_pin, pll_lock_pin}),
		.dout (pins_s)
	);

	assign reset_pin_n_s = pins_s[2];
	assign ce_s          = pins_s[1];
	assign lock_s        = pins_s[0];

	prq_rst_src u_src (
		.clk           (clk),
		.nrst          (nrst),
		.reset_pin_n_s (reset_pin_n_s),
		.ce_s          (ce_s),
		.op_reset      (op_reset)
	);

	// ==========================================================
	// State
	typedef struct packed {
		prq_pkg::prq_state_t p;
		logic                op;
	} prq_core_t;

	prq_core_t r;
	prq_core_t next_r;

	// Clear everything common to both reset kinds
	function automatic prq_pkg::prq_state_t common_clear(
		input prq_pkg::prq_state_t s
	);
		prq_pkg::prq_state_t t;
		t = s;
		t.interrupt_request_flags   = '0;
		t.interrupt_enable_flags    = '0;
		t.interrupt_priority_flag   = 1'b0;
		t.interrupt_master_enable   = 1'b0;
		t.ext_int0_mode             = '0;
		t.ext_int1_mode             = '0;
		t.ext_int2_mode             = '0;
		t.port_direction_flags      = '0;
		t.pullup_assignment_regs    = '0;
		t.basic_timer_output_enable = 1'b0;
		t.timer0_output_enable      = 1'b0;
		t.timer0_count              = prq_pkg::ZERO8;
		t.timer0_mode               = prq_pkg::ZERO8;
		t.watch_timer_mode          = prq_pkg::ZERO8;
		t.lcd_mode_reg              = '0;
		t.lcd_control_reg           = '0;
		t.serial_mode_reg           = prq_pkg::ZERO8;
		t.if_counter_mode           = '0;
		t.if_count_low              = prq_pkg::ZERO8;
		t.if_count_high             = prq_pkg::ZERO8;
		t.adc_mode_reg              = '0;
		t.adc_result_reg            = prq_pkg::ZERO8;
		t.timer0_compare_value      = prq_pkg::T0_CMP_RST;
		t.basic_timer_mode          = '0;
		t.out_buffers_on            = 1'b0;
		t.port_out_latch            = '0;
		return t;
	endfunction

	// ==========================================================
	// Next state: operating reset, else software writes and events
	always_comb begin
		next_r = r;
		next_r.op = op_reset;
		// Status pins are tracked in every mode
		next_r.p.chip_enable_flag = ce_s;
		next_r.p.pll_lock_flag    = lock_s;
		if (op_reset) begin
			// Retained: shift buffer, PLL mode, dividers, display, count
			next_r.p = common_clear(r.p);
			next_r.p.chip_enable_flag = ce_s;
			next_r.p.pll_lock_flag    = lock_s;
			next_r.p.if_count_flag    = 1'b0;
		end else begin
			// Buffers come back once reset is over
			next_r.p.out_buffers_on = 1'b1;
			if (wr.en) begin
				case (wr.sel)
					prq_pkg::SEL_IRQ_REQ:
						next_r.p.interrupt_request_flags = wr.data;
					prq_pkg::SEL_IRQ_EN:
						next_r.p.interrupt_enable_flags = wr.data;
					prq_pkg::SEL_IRQ_PRIO:
						next_r.p.interrupt_priority_flag = wr.data[0];
					prq_pkg::SEL_IME:
						next_r.p.interrupt_master_enable = wr.data[0];
					prq_pkg::SEL_EXT0:
						next_r.p.ext_int0_mode = wr.data[3:0];
					prq_pkg::SEL_EXT1:
						next_r.p.ext_int1_mode = wr.data[3:0];
					prq_pkg::SEL_EXT2:
						next_r.p.ext_int2_mode = wr.data[3:0];
					prq_pkg::SEL_PORT_DIR: begin
						if (wr.index < 4'h3)
							next_r.p.port_direction_flags[wr.index[1:0]*8 +: 8]
								= wr.data;
					end
					prq_pkg::SEL_PULLUP:
						next_r.p.pullup_assignment_regs = wr.data;
					prq_pkg::SEL_BT_MODE:
						next_r.p.basic_timer_mode = wr.data[3:0];
					prq_pkg::SEL_BT_OE:
						next_r.p.basic_timer_output_enable = wr.data[0];
					prq_pkg::SEL_T0_COUNT:
						next_r.p.timer0_count = wr.data;
					prq_pkg::SEL_T0_CMP:
						next_r.p.timer0_compare_value = wr.data;
					prq_pkg::SEL_T0_MODE:
						next_r.p.timer0_mode = wr.data;
					prq_pkg::SEL_T0_OE:
						next_r.p.timer0_output_enable = wr.data[0];
					prq_pkg::SEL_WATCH:
						next_r.p.watch_timer_mode = wr.data;
					prq_pkg::SEL_LCD_MODE:
						next_r.p.lcd_mode_reg = wr.data[3:0];
					prq_pkg::SEL_LCD_CTRL:
						next_r.p.lcd_control_reg = wr.data[3:0];
					prq_pkg::SEL_SER_MODE:
						next_r.p.serial_mode_reg = wr.data;
					prq_pkg::SEL_SER_BUF:
						next_r.p.serial_shift_buffer = wr.data;
					prq_pkg::SEL_PLL_MODE:
						next_r.p.pll_mode_reg = wr.data[3:0];
					prq_pkg::SEL_PLL_DIV:
						next_r.p.pll_divider_data[wr.index[1:0]] = wr.data[3:0];
					prq_pkg::SEL_IF_FLAG:
						next_r.p.if_count_flag = wr.data[0];
					prq_pkg::SEL_IF_MODE:
						next_r.p.if_counter_mode = wr.data[3:0];
					prq_pkg::SEL_ADC_MODE:
						next_r.p.adc_mode_reg = wr.data[3:0];
					prq_pkg::SEL_OUT_LAT: begin
						if (wr.index < 4'h3)
							next_r.p.port_out_latch[wr.index[1:0]*8 +: 8] = wr.data;
					end
					prq_pkg::SEL_DISP: begin
						if (wr.index < 4'(prq_pkg::DISP_N))
							next_r.p.display_memory[wr.index] = wr.data[3:0];
					end
					default: ;
				endcase
			end
			// Hardware events override a clear written in the same cycle
			next_r.p.interrupt_request_flags =
				next_r.p.interrupt_request_flags | irq_event;
			if (if_done) begin
				next_r.p.if_count_flag = 1'b1;
				next_r.p.if_count_low  = if_value[7:0];
				next_r.p.if_count_high = if_value[15:8];
			end
			if (adc_done)
				next_r.p.adc_result_reg = adc_data;
		end
	end

	// ==========================================================
	// Power-on reset gives defined zeros to the undefined entries
	always_ff @(posedge clk) begin
		if (!nrst) begin
			r      <= '0;
			r.p    <= common_clear('0);
		end else begin
			r <= next_r;
		end
	end

	assign regs            = r.p;
	assign op_reset_active = r.op;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence op_rst_s;
		op_reset;
	endsequence

	sequence op_rst_done_s;
		op_reset ##1 !op_reset;
	endsequence

	sequence ce_rise_s;
		ce_s && !$past(ce_s);
	endsequence

	irq_clear_a: assert property (op_rst_s |=>
		regs.interrupt_request_flags == '0)
		else $error("request flags not cleared by reset");
	irq_en_cleared_a: assert property (op_rst_s |=>
		regs.interrupt_enable_flags == '0 &&
		!regs.interrupt_priority_flag && !regs.interrupt_master_enable)
		else $error("enable, priority or master flag survived reset");
	ext_mode_clear_a: assert property (op_rst_s |=>
		{regs.ext_int0_mode, regs.ext_int1_mode, regs.ext_int2_mode} == '0)
		else $error("external interrupt mode survived reset");
	port_cfg_clear_a: assert property (op_rst_s |=>
		regs.port_direction_flags == '0 && regs.pullup_assignment_regs == '0)
		else $error("port direction or pull-up survived reset");
	t0_cmp_ones_a: assert property (op_rst_s |=>
		regs.timer0_compare_value == 8'hff && regs.timer0_count == 8'h00)
		else $error("timer 0 compare not all ones after reset");
	ser_buf_kept_a: assert property (op_rst_s |=>
		regs.serial_shift_buffer == $past(regs.serial_shift_buffer) &&
		regs.pll_mode_reg == $past(regs.pll_mode_reg))
		else $error("retained register changed on operating reset");
	ce_flag_pin_a: assert property (op_rst_s |=>
		regs.chip_enable_flag == $past(ce_s) && !regs.if_count_flag)
		else $error("chip-enable or count flag wrong after reset");
	buf_off_a: assert property (op_rst_done_s |->
		!regs.out_buffers_on ##1 regs.out_buffers_on)
		else $error("output buffers not off for reset then back on");
	ce_rise_rst_a: assert property (ce_rise_s |=>
		op_reset ##1 op_reset_active)
		else $error("chip-enable rise did not start a reset");
	pin_hold_rst_a: assert property (!reset_pin_n_s |=>
		op_reset ##1 op_reset_active)
		else $error("reset pin low did not start a reset");
	pullup_clear_a: assert property (op_rst_s |=>
		regs.pullup_assignment_regs == 8'h00)
		else $error("pull-up assignment survived reset");
	bt_oe_clear_a: assert property (op_rst_s |=>
		!regs.basic_timer_output_enable)
		else $error("basic timer output enable survived reset");
	t0_cfg_clear_a: assert property (op_rst_s |=>
		!regs.timer0_output_enable && regs.timer0_mode == 8'h00)
		else $error("timer 0 enable or mode survived reset");
	watch_clear_a: assert property (op_rst_s |=>
		regs.watch_timer_mode == 8'h00)
		else $error("watch timer mode survived reset");
	lcd_mode_clear_a: assert property (op_rst_s |=>
		regs.lcd_mode_reg == 4'h0)
		else $error("display mode survived reset");
	lcd_ctrl_clear_a: assert property (op_rst_s |=>
		regs.lcd_control_reg == 4'h0)
		else $error("display control survived reset");
	ser_mode_clear_a: assert property (op_rst_s |=>
		regs.serial_mode_reg == 8'h00)
		else $error("serial mode survived reset");
	pll_div_kept_a: assert property (op_rst_s |=>
		regs.pll_divider_data == $past(regs.pll_divider_data))
		else $error("divider data changed on operating reset");
	ce_follow_a: assert property (1'b1 |=>
		regs.chip_enable_flag == $past(ce_s))
		else $error("chip-enable flag does not follow the pin");
	ifc_mode_clear_a: assert property (op_rst_s |=>
		regs.if_counter_mode == 4'h0)
		else $error("counter mode survived reset");
	ifc_clear_a: assert property (op_rst_s |=>
		{regs.if_count_high, regs.if_count_low} == 16'h0000)
		else $error("counter value survived reset");
	adc_mode_clear_a: assert property (op_rst_s |=>
		regs.adc_mode_reg == 4'h0)
		else $error("converter mode survived reset");
	adc_result_clear_a: assert property (op_rst_s |=>
		regs.adc_result_reg == 8'h00)
		else $error("converter result survived reset");
	bt_mode_clear_a: assert property (op_rst_s |=>
		regs.basic_timer_mode == 4'h0)
		else $error("basic timer mode survived reset");
	disp_kept_a: assert property (op_rst_s |=>
		regs.display_memory == $past(regs.display_memory) &&
		regs.port_out_latch == '0 && !regs.out_buffers_on)
		else $error("display lost or port latch kept on reset");
	irq_set_wins_a: assert property (!op_reset && irq_event[0] |=>
		regs.interrupt_request_flags[0])
		else $error("request event lost against a clear");
endmodule // prq_core

// >>> pkg/prq_pkg.sv
// Shared types and reset constants of the peripheral reset initializer
package prq_pkg;

	// ==========================================================
	// Widths and counts
	localparam int IRQ_N     = 8;
	localparam int PORT_BITS = 24;
	localparam int PUP_BITS  = 8;
	localparam int PLL_DIVS  = 4;
	localparam int DISP_N    = 14;

	// ==========================================================
	// Values after reset
	localparam logic [7:0] ZERO8      = 8'h00;
	localparam logic [7:0] T0_CMP_RST = 8'hff;

	// ==========================================================
	// Software write selector
	typedef enum logic [4:0] {
		SEL_IRQ_REQ  = 5'b00000,
		SEL_IRQ_EN   = 5'b00001,
		SEL_IRQ_PRIO = 5'b00010,
		SEL_IME      = 5'b00011,
		SEL_EXT0     = 5'b00100,
		SEL_EXT1     = 5'b00101,
		SEL_EXT2     = 5'b00110,
		SEL_PORT_DIR = 5'b00111,
		SEL_PULLUP   = 5'b01000,
		SEL_BT_MODE  = 5'b01001,
		SEL_BT_OE    = 5'b01010,
		SEL_T0_COUNT = 5'b01011,
		SEL_T0_CMP   = 5'b01100,
		SEL_T0_MODE  = 5'b01101,
		SEL_T0_OE    = 5'b01110,
		SEL_WATCH    = 5'b01111,
		SEL_LCD_MODE = 5'b10000,
		SEL_LCD_CTRL = 5'b10001,
		SEL_SER_MODE = 5'b10010,
		SEL_SER_BUF  = 5'b10011,
		SEL_PLL_MODE = 5'b10100,
		SEL_PLL_DIV  = 5'b10101,
		SEL_IF_FLAG  = 5'b10110,
		SEL_IF_MODE  = 5'b10111,
		SEL_ADC_MODE = 5'b11000,
		SEL_OUT_LAT  = 5'b11001,
		SEL_DISP     = 5'b11010
	} prq_sel_t;

	typedef struct packed {
		prq_sel_t   sel;
		logic [3:0] index;
		logic [7:0] data;
		logic       en;
	} prq_wr_t;

	// ==========================================================
	// Peripheral register image
	typedef struct packed {
		logic [IRQ_N-1:0]        interrupt_request_flags;
		logic [IRQ_N-1:0]        interrupt_enable_flags;
		logic                    interrupt_priority_flag;
		logic                    interrupt_master_enable;
		logic [3:0]              ext_int0_mode;
		logic [3:0]              ext_int1_mode;
		logic [3:0]              ext_int2_mode;
		logic [PORT_BITS-1:0]    port_direction_flags;
		logic [PORT_BITS-1:0]    port_out_latch;
		logic                    out_buffers_on;
		logic [PUP_BITS-1:0]     pullup_assignment_regs;
		logic [7:0]              basic_timer_count;
		logic [3:0]              basic_timer_mode;
		logic                    basic_timer_output_enable;
		logic [7:0]              timer0_count;
		logic [7:0]              timer0_compare_value;
		logic [7:0]              timer0_mode;
		logic                    timer0_output_enable;
		logic [7:0]              watch_timer_mode;
		logic [3:0]              lcd_mode_reg;
		logic [3:0]              lcd_control_reg;
		logic [DISP_N-1:0][3:0]  display_memory;
		logic [7:0]              serial_mode_reg;
		logic [7:0]              serial_shift_buffer;
		logic [3:0]              pll_mode_reg;
		logic [PLL_DIVS-1:0][3:0] pll_divider_data;
		logic                    pll_lock_flag;
		logic                    chip_enable_flag;
		logic                    if_count_flag;
		logic [3:0]              if_counter_mode;
		logic [7:0]              if_count_low;
		logic [7:0]              if_count_high;
		logic [3:0]              adc_mode_reg;
		logic [7:0]              adc_result_reg;
	} prq_state_t;

	typedef enum logic {
		SRC_IDLE = 1'b0,
		SRC_HOLD = 1'b1
	} prq_src_st_t;

	typedef struct packed {
		prq_src_st_t st;
		logic        ce_prev;
		logic        op_reset;
	} prq_src_t;

endpackage

// >>> core/prq_sync.sv
// Two-stage synchronizer for pin inputs
`timescale 1ns/1ps
module prq_sync #(
	parameter int               W   = 1,
	parameter logic [W-1:0]     RST = '0
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	// ==========================================================
	// Stages; the first stage feeds only the second
	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta <= RST;
			dout <= RST;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // prq_sync

// >>> core/prq_rst_src.sv
// Reset source detector: reset pin hold or chip-enable rising edge
`timescale 1ns/1ps
module prq_rst_src (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic reset_pin_n_s,
	input  wire logic ce_s,
	output logic      op_reset
);
	prq_pkg::prq_src_t r;
	prq_pkg::prq_src_t next_r;

	// ==========================================================
	// Pin low holds reset; a chip-enable rise gives one cycle
	always_comb begin
		next_r = r;
		next_r.ce_prev = ce_s;
		case (r.st)
			prq_pkg::SRC_IDLE: begin
				if (!reset_pin_n_s)
					next_r.st = prq_pkg::SRC_HOLD;
			end
			prq_pkg::SRC_HOLD: begin
				if (reset_pin_n_s)
					next_r.st = prq_pkg::SRC_IDLE;
			end
			default: next_r.st = prq_pkg::SRC_IDLE;
		endcase
		// Pin reset follows the hold state; a CE rise adds one cycle
		next_r.op_reset = (next_r.st == prq_pkg::SRC_HOLD) ||
			(ce_s && !r.ce_prev);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			r <= '{st: prq_pkg::SRC_IDLE, ce_prev: 1'b0, op_reset: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign op_reset = r.op_reset;
endmodule // prq_rst_src

// >>> verif/peripheral_reset_initializer_test.sv
// Self-checking bench for the peripheral reset initializer
`timescale 1ns/1ps
module peripheral_reset_initializer_test;
	// ==========================================================
	// Clock, ports and counters
	logic                 clk;
	logic                 nrst;
	logic                 reset_pin_n;
	logic                 ce_pin;
	logic                 pll_lock_pin;
	logic [7:0]           irq_event;
	logic                 if_done;
	logic [15:0]          if_value;
	logic                 adc_done;
	logic [7:0]           adc_data;
	prq_pkg::prq_wr_t     wr;
	prq_pkg::prq_state_t  regs;
	logic                 op_reset_active;
	prq_pkg::prq_state_t  exp;
	prq_pkg::prq_state_t  msk;
	int                   failures;
	int                   checks;
	int                   cycles;
	int                   n;

	prq_core dut (
		.clk             (clk),
		.nrst            (nrst),
		.reset_pin_n     (reset_pin_n),
		.ce_pin          (ce_pin),
		.pll_lock_pin    (pll_lock_pin),
		.irq_event       (irq_event),
		.if_done         (if_done),
		.if_value        (if_value),
		.adc_done        (adc_done),
		.adc_data        (adc_data),
		.wr              (wr),
		.regs            (regs),
		.op_reset_active (op_reset_active)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Generous ceiling: the whole sequence needs a few hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			$display("mismatch at %0t: run did not complete", $time);
			tally_and_finish();
		end
	end

	// ==========================================================
	// Compare tasks
	task automatic cmp_regs(input string what);
		checks++;
		if ((regs & msk) !== (exp & msk)) begin
			failures++;
			$display("mismatch at %0t: register image after %s", $time, what);
		end
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] want,
			input string what);
		checks++;
		if (got !== want) begin
			failures++;
			$display("mismatch at %0t: %s got %h want %h", $time, what,
				got, want);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Access tasks: the write strobe stays up across back-to-back calls
	task automatic wr_op(input prq_pkg::prq_sel_t s, input int idx,
			input logic [7:0] d);
		@(posedge clk);
		wr <= '{sel: s, index: 4'(idx), data: d, en: 1'b1};
	endtask

	task automatic wr_idle();
		@(posedge clk);
		wr.en <= 1'b0;
	endtask

	// Loads every writable register with a non-reset value and raises both done strobes and request events 0 and 7
	task automatic fill();
		prq_pkg::prq_sel_t tbl[23];
		tbl = '{prq_pkg::SEL_IRQ_REQ, prq_pkg::SEL_IRQ_EN,
			prq_pkg::SEL_IRQ_PRIO,
			prq_pkg::SEL_IME, prq_pkg::SEL_EXT0, prq_pkg::SEL_EXT1,
			prq_pkg::SEL_EXT2, prq_pkg::SEL_PULLUP,
			prq_pkg::SEL_BT_MODE, prq_pkg::SEL_BT_OE,
			prq_pkg::SEL_T0_COUNT, prq_pkg::SEL_T0_CMP,
			prq_pkg::SEL_T0_MODE, prq_pkg::SEL_T0_OE,
			prq_pkg::SEL_WATCH, prq_pkg::SEL_LCD_MODE,
			prq_pkg::SEL_LCD_CTRL, prq_pkg::SEL_SER_MODE,
			prq_pkg::SEL_SER_BUF, prq_pkg::SEL_PLL_MODE,
			prq_pkg::SEL_IF_MODE, prq_pkg::SEL_ADC_MODE,
			prq_pkg::SEL_IF_FLAG};
		foreach (tbl[i]) wr_op(tbl[i], 0, 8'ha5);
		for (int i = 0; i < 3; i++) begin
			wr_op(prq_pkg::SEL_PORT_DIR, i, 8'hc3);
			wr_op(prq_pkg::SEL_OUT_LAT, i, 8'h3c);
		end
		for (int i = 0; i < prq_pkg::PLL_DIVS; i++) begin
			wr_op(prq_pkg::SEL_PLL_DIV, i, 8'(i + 6));
		end
		for (int i = 0; i < prq_pkg::DISP_N; i++) begin
			wr_op(prq_pkg::SEL_DISP, i, 8'(i + 1));
		end
		// A clear of the request flags meets the events in one cycle
		@(posedge clk);
		wr        <= '{sel: prq_pkg::SEL_IRQ_REQ, index: 4'h0,
			data: 8'h00, en: 1'b1};
		irq_event <= 8'h81;
		if_done   <= 1'b1;
		if_value  <= 16'h1234;
		adc_done  <= 1'b1;
		adc_data  <= 8'h3c;
		@(posedge clk);
		wr.en     <= 1'b0;
		irq_event <= 8'h00;
		if_done   <= 1'b0;
		adc_done  <= 1'b0;
		@(posedge clk);
		#1;
		cmp8(regs.interrupt_request_flags, 8'h81, "irq event");
		cmp8(regs.timer0_compare_value, 8'ha5, "compare write");
		cmp8(regs.adc_result_reg, 8'h3c, "adc load");
		cmp8(regs.if_count_high, 8'h12, "if load");
	endtask

	// Expected image after an operating reset, given the chip-enable level
	task automatic exp_op(input logic ce);
		exp = '0;
		exp.timer0_compare_value = prq_pkg::T0_CMP_RST;
		exp.serial_shift_buffer  = 8'ha5;
		exp.pll_mode_reg         = 4'h5;
		for (int i = 0; i < prq_pkg::PLL_DIVS; i++) begin
			exp.pll_divider_data[i] = 4'(i + 6);
		end
		for (int i = 0; i < prq_pkg::DISP_N; i++) begin
			exp.display_memory[i] = 4'(i + 1);
		end
		exp.chip_enable_flag = ce;
		msk = '1;
		msk.basic_timer_count = '0;
		msk.pll_lock_flag     = 1'b0;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		nrst         = 1'b0;
		reset_pin_n  = 1'b1;
		ce_pin       = 1'b0;
		pll_lock_pin = 1'b0;
		irq_event    = 8'h00;
		if_done      = 1'b0;
		if_value     = 16'h0000;
		adc_done     = 1'b0;
		adc_data     = 8'h00;
		wr           = '0;
		failures     = 0;
		checks       = 0;
		cycles       = 0;
		repeat (16) @(posedge clk);
		#1;
		exp = '0;
		exp.timer0_compare_value = prq_pkg::T0_CMP_RST;
		msk = '1;
		cmp_regs("power-on");
		cmp8(8'(op_reset_active), 8'h00, "op flag at power-on");
		@(posedge clk);
		nrst <= 1'b1;
		$display("test power_on done");

		// Chip-enable rise: one-cycle reset, writes around it
		fill();
		@(posedge clk);
		ce_pin <= 1'b1;
		repeat (3) @(posedge clk);
		wr <= '{sel: prq_pkg::SEL_T0_OE, index: 4'h0, data: 8'h01,
			en: 1'b1};
		@(posedge clk);
		wr <= '{sel: prq_pkg::SEL_IME, index: 4'h0, data: 8'h01,
			en: 1'b1};
		#1;
		exp_op(1'b1);
		cmp8(8'(op_reset_active), 8'h01, "ce reset latency");
		cmp_regs("ce reset");
		cmp_regs("ce reset, timers");
		cmp_regs("ce reset, retained");
		cmp_regs("ce reset, counters");
		wr_idle();
		#1;
		cmp8(8'(regs.out_buffers_on), 8'h01, "buffers back on");
		cmp8(8'(regs.interrupt_master_enable), 8'h01, "write after");
		cmp8(8'(regs.timer0_output_enable), 8'h00, "write during");
		$display("test ce_reset done");

		// Reset pin held low while chip enable stays high
		fill();
		@(posedge clk);
		reset_pin_n <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (op_reset_active !== 1'b1 && n < 20);
		cmp8(8'(n), 8'h04, "pin reset latency");
		exp_op(1'b1);
		cmp_regs("pin reset");
		repeat (5) @(posedge clk);
		#1;
		cmp_regs("pin held");
		@(posedge clk);
		reset_pin_n <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		cmp8(8'(op_reset_active), 8'h00, "op flag after pin");
		cmp8(8'(regs.out_buffers_on), 8'h01, "buffers after pin");
		$display("test pin_reset done");

		// Power-on reset in mid-run drops retained contents
		fill();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		exp = '0;
		exp.timer0_compare_value = prq_pkg::T0_CMP_RST;
		msk = '1;
		msk.pll_lock_flag = 1'b0;
		cmp_regs("second power-on");
		// After release the flag must show the chip-enable pin again
		@(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		exp.chip_enable_flag = 1'b1;
		exp.out_buffers_on   = 1'b1;
		cmp_regs("after second power-on");
		cmp8(8'(op_reset_active), 8'h00, "op flag settles");
		$display("test second_power_on done");
		tally_and_finish();
	end
endmodule // peripheral_reset_initializer_test
